// [hw/csel_clock_select.sv]
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - configuration 11/10/01 pick external high/medium/low power, 00 internal block
// - configuration field sets default source at power-up and every reset
// - select field cleared means run from the configured source
// - HF oscillator on for HF tap when config is internal or select is 1x
// - LF oscillator on and used when select 000x with internal block chosen
// - LF oscillator runs whenever power-up or watchdog timer is enabled
// - HF ready flag shows HF oscillator running
// - HF stable flag set only after settling within 0.5 percent
// - LF ready flag shows LF oscillator running
// - mux offers ten postscaled HF taps plus LF 31 kHz
// - every reset loads frequency select with 0111, 500 kHz
// - same-source frequency changes skip start-up, so finish faster
// - external clock modes start with no added delay
// - static logic: stopped external clock halts, resumes with state kept
// - internal mode frees clock input pin; output pin per clock-out enable
// - fast start-up flag marks the wait for HF oscillator start-up; no separate clock runs logic
// - frequency select decodes to the listed frequencies and duplicates
// - select field: 1x internal, 01 reserved, 00 configured; reset clears it
// - stopped new oscillator: start-up delay, then old falling edge, then switch
// - clock-out enable 1 leaves pin as I/O, 0 drives system clock out
module csel_clock_select #(
  parameter int LF_START_CYCLES = csel_pkg::LF_START_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // configuration word and external clock pin
  input wire csel_pkg::csel_cfg_t CFG,
  input wire logic EXT_CLOCK_IN_PIN,
  // register port
  input wire csel_pkg::csel_bus_req_t BUS_REQ,
  output logic [csel_pkg::DATA_W-1:0] RD_DATA,
  // clock outputs and pin control
  output logic SYSCLK_OUT,
  output logic SYSCLK_OUTPUT_PIN_O,
  output logic SYSCLK_OUTPUT_PIN_OE_N,
  output logic EXT_CLOCK_IN_PIN_IS_GPIO,
  output logic LF_TIMEBASE,
  // status
  output logic FAST_STARTUP_ACTIVE,
  output logic SWITCH_BUSY,
  output csel_pkg::csel_src_t ACTIVE_SOURCE,
  output csel_pkg::csel_pwr_t EXT_PWR_MODE
);
  import csel_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_START, ST_OLD_FALL, ST_NEW_LOW} csel_state_t;

  csel_cfg_t cfg_sync;
  csel_cfg_t cfg_ff;
  logic ext_lvl;
  logic [IFS_W-1:0] ifs_ff;
  logic [SEL_W-1:0] sel_ff;
  csel_state_t state_ff;
  csel_src_t cur_src_ff;
  csel_src_t pend_src_ff;
  logic [TAP_W-1:0] cur_tap_ff;
  logic [TAP_W-1:0] pend_tap_ff;
  logic live_ff;
  logic cur_prev_ff;
  logic pend_prev_ff;
  logic sys_clk_ff;
  logic [POST_W-1:0] post_ff;
  logic hf_lvl;
  logic hf_rise;
  logic hf_ready;
  logic hf_stable;
  logic lf_lvl;
  logic lf_ready;
  logic hf_en;
  logic lf_en;
  logic int_sel;
  logic ifs_lf;
  logic timers_on;
  csel_src_t tgt_src;
  logic [TAP_W-1:0] tgt_tap;
  logic [POST_W:0] taps;
  logic cur_lvl;
  logic pend_lvl;
  logic pend_ready;
  logic tgt_ready;
  logic need_switch;
  logic nxt_sys_clk;

  // pins from outside the clock domain pass two flops first
  csel_sync #(.W($bits(csel_cfg_t) + 1)) u_sync (
    .clk(MCLK),
    .d({CFG, EXT_CLOCK_IN_PIN}),
    .q({cfg_sync, ext_lvl})
  );

  // configuration word is caught while reset is held
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_ff <= cfg_sync;
    end
  end

  // software control fields
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ifs_ff <= IFS_RESET;
      sel_ff <= SEL_RESET;
    end else if (BUS_REQ.wr && BUS_REQ.addr == OSC_CTRL_ADDR) begin
      ifs_ff <= BUS_REQ.wdata[CTRL_IFS_LSB +: IFS_W];
      sel_ff <= BUS_REQ.wdata[CTRL_SEL_LSB +: SEL_W];
    end
  end

  // read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge MCLK) begin
    RD_DATA <= '0;
    if (!SRST && BUS_REQ.rd) begin
      if (BUS_REQ.addr == OSC_CTRL_ADDR) begin
        RD_DATA[CTRL_IFS_LSB +: IFS_W] <= ifs_ff;
        RD_DATA[CTRL_SEL_LSB +: SEL_W] <= sel_ff;
      end else if (BUS_REQ.addr == OSC_STAT_ADDR) begin
        RD_DATA[STAT_HF_READY_BIT] <= hf_ready;
        RD_DATA[STAT_LF_READY_BIT] <= lf_ready;
        RD_DATA[STAT_HF_STABLE_BIT] <= hf_stable;
      end
    end
  end

  // source target; the reserved select code 01 behaves as 00
  always_comb begin
    int_sel = sel_ff[1] || (cfg_ff.osc_source_cfg == OSC_CFG_INTERNAL);
    ifs_lf = (ifs_ff[3:1] == 3'b000);
    tgt_src = !int_sel ? SRC_EXT : (ifs_lf ? SRC_LF : SRC_HF);
    tgt_tap = ifs_tap(ifs_ff);
    timers_on = !cfg_ff.powerup_timer_en_n || (cfg_ff.watchdog_timer_mode != WDOG_OFF);
  end

  // oscillators stay on while either side of a switch needs them
  always_comb begin
    hf_en = (tgt_src == SRC_HF) || (pend_src_ff == SRC_HF) || (cur_src_ff == SRC_HF);
    lf_en = (tgt_src == SRC_LF) || (pend_src_ff == SRC_LF) || (cur_src_ff == SRC_LF)
      || timers_on;
  end

  csel_osc #(
    .HALF_CYC(HF_HALF_CYC),
    .START_CYC(HF_START_CYC),
    .STABLE_CYC(HF_STABLE_CYC)
  ) u_hf_osc (
    .clk(MCLK),
    .srst(SRST),
    .en(hf_en),
    .osc_o(hf_lvl),
    .rise_o(hf_rise),
    .ready_o(hf_ready),
    .stable_o(hf_stable)
  );

  csel_osc #(
    .HALF_CYC(LF_HALF_CYC),
    .START_CYC(LF_START_CYCLES),
    .STABLE_CYC(1)
  ) u_lf_osc (
    .clk(MCLK),
    .srst(SRST),
    .en(lf_en),
    .osc_o(lf_lvl),
    .rise_o(),
    .ready_o(lf_ready),
    .stable_o()
  );

  // ripple postscaler; every tap divides the one HF oscillator
  always_ff @(posedge MCLK) begin
    if (SRST || !hf_ready) begin
      post_ff <= '0;
    end else if (hf_rise) begin
      post_ff <= post_ff + 1'b1;
    end
  end

  // clock level per source; external is always considered ready
  always_comb begin
    taps = {post_ff, hf_lvl};
    cur_lvl = 1'b0;
    pend_lvl = 1'b0;
    pend_ready = 1'b1;
    tgt_ready = 1'b1;
    unique case (cur_src_ff)
      SRC_EXT: cur_lvl = ext_lvl;
      SRC_HF: cur_lvl = taps[cur_tap_ff];
      SRC_LF: cur_lvl = lf_lvl;
      default: cur_lvl = 1'b0;
    endcase
    unique case (pend_src_ff)
      SRC_EXT: pend_lvl = ext_lvl;
      SRC_HF: pend_lvl = taps[pend_tap_ff];
      SRC_LF: pend_lvl = lf_lvl;
      default: pend_lvl = 1'b0;
    endcase
    if (pend_src_ff == SRC_HF) pend_ready = hf_ready;
    if (pend_src_ff == SRC_LF) pend_ready = lf_ready;
    if (tgt_src == SRC_HF) tgt_ready = hf_ready;
    if (tgt_src == SRC_LF) tgt_ready = lf_ready;
    need_switch = (tgt_src != cur_src_ff) || (tgt_src == SRC_HF && tgt_tap != cur_tap_ff)
      || !live_ff;
  end

  // switch sequence; a stopped external clock simply stalls it
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_ff <= ST_RUN;
      pend_src_ff <= SRC_EXT;
      pend_tap_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          if (need_switch) begin
            pend_src_ff <= tgt_src;
            pend_tap_ff <= tgt_tap;
            state_ff <= !tgt_ready ? ST_START : (live_ff ? ST_OLD_FALL : ST_NEW_LOW);
          end
        end
        ST_START: begin
          if (pend_ready) begin
            state_ff <= live_ff ? ST_OLD_FALL : ST_NEW_LOW;
          end
        end
        ST_OLD_FALL: begin
          if (cur_prev_ff && !cur_lvl) begin
            state_ff <= ST_NEW_LOW;
          end
        end
        ST_NEW_LOW: begin
          if (pend_prev_ff && !pend_lvl) begin
            state_ff <= ST_RUN;
          end
        end
      endcase
    end
  end

  // hand over on a falling edge of the new clock, so its low phase is whole
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cur_src_ff <= SRC_EXT;
      cur_tap_ff <= '0;
      live_ff <= 1'b0;
    end else if (state_ff == ST_NEW_LOW && pend_prev_ff && !pend_lvl) begin
      cur_src_ff <= pend_src_ff;
      cur_tap_ff <= pend_tap_ff;
      live_ff <= 1'b1;
    end
  end

  // output is forced low between the old and the new falling edge
  always_comb begin
    nxt_sys_clk = cur_lvl && live_ff;
    if (state_ff == ST_NEW_LOW) nxt_sys_clk = 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cur_prev_ff <= 1'b0;
      pend_prev_ff <= 1'b0;
      sys_clk_ff <= 1'b0;
    end else begin
      cur_prev_ff <= cur_lvl;
      pend_prev_ff <= pend_lvl;
      sys_clk_ff <= nxt_sys_clk;
    end
  end

  // registered outputs; pin enable is low while the pin is driven
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SYSCLK_OUT <= 1'b0;
      SYSCLK_OUTPUT_PIN_O <= 1'b0;
      SYSCLK_OUTPUT_PIN_OE_N <= 1'b1;
      EXT_CLOCK_IN_PIN_IS_GPIO <= 1'b0;
      LF_TIMEBASE <= 1'b0;
      FAST_STARTUP_ACTIVE <= 1'b0;
      SWITCH_BUSY <= 1'b0;
      ACTIVE_SOURCE <= SRC_EXT;
    end else begin
      SYSCLK_OUT <= sys_clk_ff;
      SYSCLK_OUTPUT_PIN_O <= sys_clk_ff && !cfg_ff.clock_output_enable_n;
      SYSCLK_OUTPUT_PIN_OE_N <= cfg_ff.clock_output_enable_n;
      EXT_CLOCK_IN_PIN_IS_GPIO <= (cfg_ff.osc_source_cfg == OSC_CFG_INTERNAL);
      LF_TIMEBASE <= lf_lvl && timers_on;
      FAST_STARTUP_ACTIVE <= (state_ff == ST_START) && (pend_src_ff == SRC_HF);
      SWITCH_BUSY <= (state_ff != ST_RUN);
      ACTIVE_SOURCE <= cur_src_ff;
    end
  end

  // external power range decode, kept even while the internal block runs
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      EXT_PWR_MODE <= PWR_INTERNAL;
    end else begin
      unique case (cfg_ff.osc_source_cfg)
        OSC_CFG_EXT_HIGH: EXT_PWR_MODE <= PWR_EXT_HIGH;
        OSC_CFG_EXT_MED: EXT_PWR_MODE <= PWR_EXT_MED;
        OSC_CFG_EXT_LOW: EXT_PWR_MODE <= PWR_EXT_LOW;
        OSC_CFG_INTERNAL: EXT_PWR_MODE <= PWR_INTERNAL;
      endcase
    end
  end

  // checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);

  property p_reset_fields;
    $fell(SRST) |-> ifs_ff == IFS_RESET && sel_ff == SEL_RESET;
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("reset field values wrong");

  property p_cfg_source;
    sel_ff == 2'h0 && state_ff == ST_RUN && cfg_ff.osc_source_cfg != OSC_CFG_INTERNAL
      |=> state_ff != ST_RUN || cur_src_ff == SRC_EXT;
  endproperty
  a_cfg_source: assert property (p_cfg_source) else $error("cleared select not on config source");

  property p_hf_enable;
    !ifs_lf && int_sel |-> hf_en;
  endproperty
  a_hf_enable: assert property (p_hf_enable) else $error("hf oscillator not enabled");

  property p_timers_lf;
    timers_on |-> lf_en ##1 (lf_en || !timers_on);
  endproperty
  a_timers_lf: assert property (p_timers_lf) else $error("lf stopped with timers on");

  property p_stat_read;
    BUS_REQ.rd && BUS_REQ.addr == OSC_STAT_ADDR |=>
      RD_DATA[STAT_HF_READY_BIT] == $past(hf_ready) && RD_DATA[STAT_LF_READY_BIT] == $past(lf_ready);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read mismatch");

  property p_stable_after_ready;
    hf_stable |-> hf_ready && $past(hf_ready);
  endproperty
  a_stable_after_ready: assert property (p_stable_after_ready) else $error("stable before ready");

  property p_ext_no_delay;
    state_ff == ST_RUN && need_switch && tgt_src == SRC_EXT |=> state_ff != ST_START;
  endproperty
  a_ext_no_delay: assert property (p_ext_no_delay) else $error("start-up wait for external");

  property p_start_holds;
    state_ff == ST_START && !pend_ready |=> state_ff == ST_START;
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("left start-up early");

  property p_low_gap;
    state_ff == ST_NEW_LOW |=> !sys_clk_ff;
  endproperty
  a_low_gap: assert property (p_low_gap) else $error("clock high during switch gap");

  property p_pin_release;
    cfg_ff.clock_output_enable_n ##1 cfg_ff.clock_output_enable_n |-> SYSCLK_OUTPUT_PIN_OE_N;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("clock pin driven when disabled");

  c_to_hf: cover property (state_ff == ST_START && pend_src_ff == SRC_HF ##1 pend_ready);
  c_to_lf: cover property (state_ff == ST_NEW_LOW && pend_src_ff == SRC_LF && !pend_lvl);
  c_tap_change: cover property (state_ff == ST_RUN && need_switch && tgt_src == SRC_HF
    && cur_src_ff == SRC_HF);
  c_to_ext: cover property (state_ff == ST_NEW_LOW && pend_src_ff == SRC_EXT);
endmodule
`default_nettype wire

// [hw/csel_osc.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural oscillator: start-up wait, then a free square wave
module csel_osc
  import csel_pkg::*;
#(
  parameter int HALF_CYC = 3,
  parameter int START_CYC = 200,
  parameter int STABLE_CYC = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  output logic osc_o,
  output logic rise_o,
  output logic ready_o,
  output logic stable_o
);
  localparam logic [OSC_CNT_W-1:0] HALF_LAST = OSC_CNT_W'(HALF_CYC - 1);
  localparam logic [OSC_CNT_W-1:0] START_LAST = OSC_CNT_W'(START_CYC - 1);
  localparam logic [OSC_CNT_W-1:0] STABLE_LAST = OSC_CNT_W'(STABLE_CYC - 1);

  logic [OSC_CNT_W-1:0] wait_ff;
  logic [OSC_CNT_W-1:0] half_ff;

  // start-up and settling timer; disabling drops both flags at once
  always_ff @(posedge clk) begin
    if (srst || !en) begin
      wait_ff <= '0;
      ready_o <= 1'b0;
      stable_o <= 1'b0;
    end else if (!ready_o) begin
      wait_ff <= (wait_ff == START_LAST) ? '0 : wait_ff + 1'b1;
      ready_o <= (wait_ff == START_LAST);
    end else if (!stable_o) begin
      wait_ff <= wait_ff + 1'b1;
      stable_o <= (wait_ff == STABLE_LAST);
    end
  end

  // square wave only once running, so no runt before ready
  always_ff @(posedge clk) begin
    if (srst || !ready_o) begin
      half_ff <= '0;
      osc_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      half_ff <= (half_ff == HALF_LAST) ? '0 : half_ff + 1'b1;
      osc_o <= (half_ff == HALF_LAST) ? !osc_o : osc_o;
      rise_o <= (half_ff == HALF_LAST) && !osc_o;
    end
  end
endmodule
`default_nettype wire

// [hw/csel_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser, one chain per bit
module csel_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_ff;
    logic hold_ff;
    // the first stage feeds only the second
    always_ff @(posedge clk) begin
      meta_ff <= d[i];
      hold_ff <= meta_ff;
    end
    assign q[i] = hold_ff;
  end
endmodule
`default_nettype wire

// [include/csel_pkg.sv]
package csel_pkg;

  // reference clock and oscillator rates
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int HF_FREQ_KHZ = 16000;
  localparam int LF_FREQ_KHZ = 31;
  localparam int HF_HALF_CYC = CLK_FREQ_KHZ / (2 * HF_FREQ_KHZ);
  localparam int LF_HALF_CYC = CLK_FREQ_KHZ / (2 * LF_FREQ_KHZ);

  // start-up and settling times, least times round up
  localparam int HF_START_NS = 2000;
  localparam int HF_START_CYC = (HF_START_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int HF_STABLE_NS = 5000;
  localparam int HF_STABLE_CYC = (HF_STABLE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int LF_START_PERIODS = 2;
  localparam int LF_START_CYC = LF_START_PERIODS * 2 * LF_HALF_CYC;
  localparam int OSC_CNT_W = 16;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] OSC_STAT_ADDR = 8'h04;
  localparam int CTRL_IFS_LSB = 3;
  localparam int IFS_W = 4;
  localparam int CTRL_SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam logic [IFS_W-1:0] IFS_RESET = 4'h7;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam int STAT_HF_READY_BIT = 4;
  localparam int STAT_LF_READY_BIT = 1;
  localparam int STAT_HF_STABLE_BIT = 0;

  // source configuration codes
  localparam logic [1:0] OSC_CFG_INTERNAL = 2'h0;
  localparam logic [1:0] OSC_CFG_EXT_LOW = 2'h1;
  localparam logic [1:0] OSC_CFG_EXT_MED = 2'h2;
  localparam logic [1:0] OSC_CFG_EXT_HIGH = 2'h3;
  localparam logic [1:0] WDOG_OFF = 2'h0;

  // postscaler taps: 0 is the raw 16 MHz, 9 is 31.25 kHz
  localparam int TAP_W = 4;
  localparam int POST_W = 9;

  typedef enum logic [1:0] {SRC_EXT, SRC_HF, SRC_LF} csel_src_t;
  typedef enum logic [1:0] {PWR_INTERNAL, PWR_EXT_LOW, PWR_EXT_MED, PWR_EXT_HIGH} csel_pwr_t;

  typedef struct packed {
    logic [1:0] osc_source_cfg;
    logic clock_output_enable_n;
    logic powerup_timer_en_n;
    logic [1:0] watchdog_timer_mode;
  } csel_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csel_bus_req_t;

  // frequency select to postscaler tap
  function automatic logic [TAP_W-1:0] ifs_tap(input logic [IFS_W-1:0] ifs);
    logic [TAP_W-1:0] t;
    t = 4'h9;
    unique case (ifs)
      4'hF: t = 4'h0;
      4'hE: t = 4'h1;
      4'hD: t = 4'h2;
      4'hC: t = 4'h3;
      4'hB: t = 4'h4;
      4'hA, 4'h7: t = 4'h5;
      4'h9, 4'h6: t = 4'h6;
      4'h8, 4'h5: t = 4'h7;
      4'h4: t = 4'h8;
      default: t = 4'h9;
    endcase
    return t;
  endfunction

endpackage

// [testbench/csel_clock_select_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module csel_clock_select_tb;
  import csel_pkg::*;
  localparam int LF_START = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  csel_cfg_t cfg = '0;
  csel_bus_req_t bus_req = '0;
  logic ext_pin, sysclk_out, pin_o, pin_oe_n, pin_gpio, lf_tb, fsa, busy;
  logic ext_run = 1'b1;
  logic [15:0] ext_half = 16'h50;
  logic [7:0] rd_data;
  csel_src_t active_src;
  csel_pwr_t ext_mode;
  int n_errors = 0;
  int cmp_count = 0;
  int n_edges = 0;
  int glitch_run = 0;
  logic prev_out = 1'b0;
  logic fsa_seen = 1'b0;

  always #5 mclk = ~mclk;

  csel_ext_clk_src ext_src (.run(ext_run), .half_ns(ext_half), .clk_o(ext_pin));

  // short start-up count keeps the LF switch affordable in simulation
  csel_clock_select #(.LF_START_CYCLES(LF_START)) DUT (
    .MCLK(mclk), .SRST(srst), .CFG(cfg), .EXT_CLOCK_IN_PIN(ext_pin),
    .BUS_REQ(bus_req), .RD_DATA(rd_data), .SYSCLK_OUT(sysclk_out),
    .SYSCLK_OUTPUT_PIN_O(pin_o), .SYSCLK_OUTPUT_PIN_OE_N(pin_oe_n),
    .EXT_CLOCK_IN_PIN_IS_GPIO(pin_gpio), .LF_TIMEBASE(lf_tb),
    .FAST_STARTUP_ACTIVE(fsa), .SWITCH_BUSY(busy), .ACTIVE_SOURCE(active_src),
    .EXT_PWR_MODE(ext_mode)
  );

  // high pulses on the system clock never shorter than the fastest half period
  always @(posedge mclk) begin
    if (srst) begin
      glitch_run = 100;
    end else if (sysclk_out !== prev_out) begin
      if (prev_out === 1'b1) check(16'(glitch_run >= 3), 16'h1);
      n_edges = n_edges + 1;
      glitch_run = 1;
    end else begin
      glitch_run = glitch_run + 1;
    end
    prev_out = sysclk_out;
    if (fsa === 1'b1) fsa_seen = 1'b1;
    if (srst === 1'b0) check(pin_o, (pin_oe_n === 1'b0) ? sysclk_out : 1'b0);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    wrap_up();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic poll_stat(input int b, input logic [7:0] exp);
    logic [7:0] d = 8'h00;
    for (int n = 0; n < 3000 && d[b] !== 1'b1; n++) rd(OSC_STAT_ADDR, d);
    check(d, exp);
    if (d[b] !== 1'b1) wrap_up();
  endtask

  task automatic wait_src(input csel_src_t s, input int bound);
    for (int n = 0; n < bound && active_src !== s; n++) begin
      @(posedge mclk);
      #1;
    end
    check(active_src, s);
    if (active_src !== s) wrap_up();
  endtask

  // busy rises two cycles after the write, so look only after three edges
  task automatic wait_idle(output int cyc);
    repeat (3) @(posedge mclk);
    #1;
    cyc = 3;
    while (busy === 1'b1 && cyc < 9000) begin
      @(posedge mclk);
      #1;
      cyc++;
    end
    if (cyc >= 9000) hang();
  endtask

  // rising edge to rising edge of the system clock, in MCLK cycles
  task automatic measure(output int per);
    int t0 = -1;
    logic p;
    per = 0;
    p = sysclk_out;
    for (int n = 0; n < 8000 && per == 0; n++) begin
      @(posedge mclk);
      #1;
      if (sysclk_out === 1'b1 && p === 1'b0) begin
        if (t0 >= 0) per = n - t0;
        else t0 = n;
      end
      p = sysclk_out;
    end
    if (per == 0) hang();
  endtask

  task automatic do_reset(input csel_cfg_t c);
    @(posedge mclk);
    srst <= 1'b1;
    cfg <= c;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // main sequence
  initial begin
    csel_cfg_t c;
    int per, cyc, tap;
    int e0;
    logic [7:0] sel[5] = '{8'h7A, 8'h79, 8'h7A, 8'h78, 8'h7A};
    csel_src_t src[5] = '{SRC_HF, SRC_EXT, SRC_HF, SRC_EXT, SRC_HF};
    c = '{osc_source_cfg: OSC_CFG_INTERNAL, clock_output_enable_n: 1'b0,
          powerup_timer_en_n: 1'b1, watchdog_timer_mode: WDOG_OFF};
    do_reset(c);
    check_rd(OSC_CTRL_ADDR, 8'h38);
    check_rd(8'h10, 8'h00);
    wr(8'h10, 8'hFF);
    check_rd(OSC_CTRL_ADDR, 8'h38);
    check(ext_mode, PWR_INTERNAL);
    check(pin_gpio, 1'b1);
    check(pin_oe_n, 1'b0);
    poll_stat(STAT_HF_READY_BIT, 8'h10);
    poll_stat(STAT_HF_STABLE_BIT, 8'h11);
    wait_src(SRC_HF, 100);
    // every HF frequency code, reserved bits written high
    for (int i = 15; i >= 2; i--) begin
      tap = (i >= 8) ? 15 - i : ((i >= 4) ? 12 - i : 9);
      wr(OSC_CTRL_ADDR, {1'b1, 4'(i), 3'b110});
      check_rd(OSC_CTRL_ADDR, {1'b0, 4'(i), 3'b010});
      wait_idle(cyc);
      measure(per);
      check(16'(per), 16'(6 << tap));
    end
    wr(OSC_CTRL_ADDR, 8'h02);
    wait_src(SRC_LF, 9000);
    poll_stat(STAT_LF_READY_BIT, 8'h02);
    measure(per);
    check(16'(per), 16'(2 * LF_HALF_CYC));
    fsa_seen = 1'b0;
    wr(OSC_CTRL_ADDR, 8'h7A);
    wait_idle(cyc);
    check(16'(cyc >= 200), 16'h1);
    check(fsa_seen, 1'b1);
    wait_src(SRC_HF, 100);
    fsa_seen = 1'b0;
    wr(OSC_CTRL_ADDR, 8'h72);
    wait_idle(cyc);
    check(16'(cyc < 200), 16'h1);
    check(fsa_seen, 1'b0);
    $display("test internal block done");
    // each external power range with a clock inside its range
    for (int m = 3; m >= 1; m--) begin
      ext_half = (m == 3) ? 16'h50 : ((m == 2) ? 16'hC8 : 16'h44C);
      c.osc_source_cfg = 2'(m);
      c.clock_output_enable_n = 1'b1;
      do_reset(c);
      check(ext_mode, csel_pwr_t'(m));
      check(pin_gpio, 1'b0);
      check(pin_oe_n, 1'b1);
      wait_src(SRC_EXT, 4 * ext_half / 10 + 10);
      check_rd(OSC_STAT_ADDR, 8'h00);
      measure(per);
      check(16'(per), 16'(ext_half / 5));
    end
    $display("test external ranges done");
    ext_half = 16'h50;
    c = '{osc_source_cfg: OSC_CFG_EXT_HIGH, clock_output_enable_n: 1'b0,
          powerup_timer_en_n: 1'b0, watchdog_timer_mode: WDOG_OFF};
    do_reset(c);
    check(pin_oe_n, 1'b0);
    poll_stat(STAT_LF_READY_BIT, 8'h02);
    for (int n = 0; n < 4000 && lf_tb !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    check(lf_tb, 1'b1);
    // stop the external clock mid-run, then restart it
    ext_run = 1'b0;
    // let the last pin edge drain through synchroniser and output flops
    repeat (8) @(posedge mclk);
    e0 = n_edges;
    repeat (300) @(posedge mclk);
    check(16'(n_edges - e0), 16'h0);
    ext_run = 1'b1;
    measure(per);
    check(16'(per), 16'h10);
    for (int i = 0; i < 5; i++) begin
      wr(OSC_CTRL_ADDR, sel[i]);
      wait_src(src[i], 4000);
    end
    do_reset(c);
    check_rd(OSC_CTRL_ADDR, 8'h38);
    wait_src(SRC_EXT, 42);
    $display("test switching and static hold done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [testbench/csel_ext_clk_src.sv]
`timescale 1ns/10ps
`default_nettype none
// logic-level clock source that drives the clock input pin
module csel_ext_clk_src (
  // control from the bench
  input wire logic run,
  input wire logic [15:0] half_ns,
  // clock pin
  output logic clk_o
);
  initial begin
    clk_o = 1'b0;
  end

  // phase unrelated to the system clock; a stopped clock keeps its level
  always begin
    #(half_ns == 16'h0 ? 1 : half_ns);
    if (run) begin
      clk_o = ~clk_o;
    end
  end
endmodule
`default_nettype wire
